/* File: pkg/low_power_receive_state_rx_pkg.sv */
// Package with constants and types for the low-power UART receive path.
// Contract
// - Receive frames in stop mode when enabled.
// - Without enable, stop mode halts all reception.
// - Low-power receive needs on-chip oscillator clock.
// - Suppress bit blocks error flags and interrupt.
// - Valid receive edge moves stop into low_power_receive_state.
// - Short pulse enters low_power_receive_state and stays there without transfer.
package low_power_receive_state_rx_pkg;
  // ************************************************************
  // Widths and timing.
  // ************************************************************
  localparam int DATA_W = 8;
  localparam int DIV_W = 16;
  localparam logic [DIV_W-1:0] DIV_RESET = 16'h015B;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  // ************************************************************
  // Power and receiver state types.
  // ************************************************************
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_STOP = 2'b01,
    PWR_LOW_POWER_RECEIVE_STATE = 2'b10
  } pwr_state_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOPB = 2'b11
  } rx_state_e;
endpackage : low_power_receive_state_rx_pkg

/* File: pkg/rx_frame_if.sv */
// Interface carrying received frames from the shifter to the control logic.
`timescale 1ns/10ps
interface rx_frame_if;
  logic [7:0] data;
  logic done;
  logic parity_err;
  logic framing_err;
  logic busy;
  logic start_seen;
  modport shifter (output data, done, parity_err, framing_err, busy, start_seen);
  modport ctrl (input data, done, parity_err, framing_err, busy, start_seen);
endinterface : rx_frame_if

/* File: rtl/rx_shifter.sv */
// Module that samples the serial input and assembles 8-bit frames with parity.
`timescale 1ns/10ps
module rx_shifter (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic run,
  input wire logic rx_in,
  input wire logic parity_en,
  input wire logic parity_odd,
  input wire logic [low_power_receive_state_rx_pkg::DIV_W-1:0] bit_div,
  rx_frame_if.shifter frm
);
  import low_power_receive_state_rx_pkg::*;

  rx_state_e state_q;
  logic [DIV_W-1:0] cnt_q;
  logic [3:0] bit_q;
  logic [8:0] shift_q;
  logic rx_prev_q;
  wire fall = rx_prev_q & ~rx_in;
  wire tick = (cnt_q == '0);
  wire [DIV_W-1:0] half_div = bit_div >> 1;
  wire [3:0] last_bit = parity_en ? 4'h8 : 4'h7;
  wire par_calc = ^shift_q[7:0] ^ parity_odd;

  // Walks start, data, optional parity and stop bit, sampling mid-bit.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_q <= RX_IDLE;
      cnt_q <= '0;
      bit_q <= 4'h0;
      shift_q <= 9'h000;
      rx_prev_q <= 1'b1;
      frm.done <= 1'b0;
      frm.start_seen <= 1'b0;
      frm.parity_err <= 1'b0;
      frm.framing_err <= 1'b0;
      frm.data <= DATA_RESET;
    end else if (clk_en) begin
      rx_prev_q <= rx_in;
      frm.done <= 1'b0;
      frm.start_seen <= 1'b0;
      if (!run) begin
        state_q <= RX_IDLE;
      end else begin
        cnt_q <= tick ? bit_div : cnt_q - 1'b1;
        unique case (state_q)
          RX_IDLE: begin
            if (fall) begin
              state_q <= RX_START;
              cnt_q <= half_div;
            end
          end
          RX_START: begin
            // A pulse gone before mid-bit is not a start bit.
            if (tick) begin
              state_q <= rx_in ? RX_IDLE : RX_DATA;
              frm.start_seen <= ~rx_in;
              bit_q <= 4'h0;
            end
          end
          RX_DATA: begin
            if (tick) begin
              shift_q[bit_q] <= rx_in;
              bit_q <= bit_q + 4'h1;
              if (bit_q == last_bit) begin
                state_q <= RX_STOPB;
              end
            end
          end
          RX_STOPB: begin
            if (tick) begin
              state_q <= RX_IDLE;
              frm.done <= 1'b1;
              frm.data <= shift_q[7:0];
              frm.framing_err <= ~rx_in;
              frm.parity_err <= parity_en & (par_calc != shift_q[8]);
            end
          end
        endcase
      end
    end
  end

  assign frm.busy = (state_q != RX_IDLE);
endmodule : rx_shifter

/* File: rtl/low_power_receive_state_uart_rx.sv */
// Top of the UART receive path with stop-mode low_power_receive_state wake behaviour.
`timescale 1ns/10ps
module low_power_receive_state_uart_rx #(
  parameter logic [low_power_receive_state_rx_pkg::DIV_W-1:0] BIT_DIV = low_power_receive_state_rx_pkg::DIV_RESET
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic serial_receive_pin,
  input wire logic stop_req,
  input wire logic cpu_wake,
  input wire logic hs_onchip_osc_clock,
  input wire logic low_power_receive_state_wake_enable,
  input wire logic low_power_receive_state_error_suppress,
  input wire logic error_irq_output_control,
  input wire logic parity_en,
  input wire logic parity_odd,
  input wire logic data_read,
  input wire logic clear_errors,
  output logic [low_power_receive_state_rx_pkg::DATA_W-1:0] serial_receive_data_reg,
  output logic parity_error_flag,
  output logic framing_error_flag,
  output logic overrun_error_flag,
  output logic receive_complete_irq,
  output logic receive_error_irq,
  output logic transfer_active_flag,
  output logic low_power_receive_state,
  output logic cpu_stopped
);
  import low_power_receive_state_rx_pkg::*;

  // ************************************************************
  // Power state and receiver gating.
  // ************************************************************
  pwr_state_e pwr_q;
  logic full_q;
  rx_frame_if frm ();

  // Low_power_receive_state is legal only on the on-chip oscillator clock.
  wire low_power_receive_state_ok = low_power_receive_state_wake_enable & hs_onchip_osc_clock;
  wire in_run = (pwr_q == PWR_RUN);
  // Receiver runs in normal mode or while low_power_receive_state is allowed.
  wire rx_run = in_run | low_power_receive_state_ok;
  wire valid_edge = (pwr_q == PWR_STOP) & low_power_receive_state_ok & ~serial_receive_pin;
  wire frame_ok = frm.done & ~frm.parity_err & ~frm.framing_err;
  wire overrun = frm.done & full_q & ~data_read;
  wire any_err = frm.done & (frm.parity_err | frm.framing_err) | overrun;
  // Suppression masks error flags and interrupts, not the wake decision.
  wire err_take = any_err & ~low_power_receive_state_error_suppress;
  wire good_done = frm.done & ~(any_err & low_power_receive_state_error_suppress);

  // Frame sampling and assembly.
  rx_shifter u_shift (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .run(rx_run),
    .rx_in(serial_receive_pin),
    .parity_en(parity_en),
    .parity_odd(parity_odd),
    .bit_div(BIT_DIV),
    .frm(frm.shifter)
  );

  // Power state machine: stop, low_power_receive_state on edge, run on good frame.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pwr_q <= PWR_RUN;
    end else if (clk_en) begin
      unique case (pwr_q)
        PWR_RUN: begin
          if (stop_req) begin
            pwr_q <= PWR_STOP;
          end
        end
        PWR_STOP: begin
          if (cpu_wake) begin
            pwr_q <= PWR_RUN;
          end else if (valid_edge) begin
            pwr_q <= PWR_LOW_POWER_RECEIVE_STATE;
          end
        end
        PWR_LOW_POWER_RECEIVE_STATE: begin
          // Stays here if no start bit ever qualifies.
          if (cpu_wake || (frame_ok && !overrun)) begin
            pwr_q <= PWR_RUN;
          end else if (frm.done && !frm.busy) begin
            pwr_q <= PWR_STOP;
          end
        end
        default: begin
          pwr_q <= PWR_RUN;
        end
      endcase
    end
  end

  // Data register, flags and interrupt pulses; a new error beats a clear.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      serial_receive_data_reg <= DATA_RESET;
      full_q <= 1'b0;
      parity_error_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      overrun_error_flag <= 1'b0;
      receive_complete_irq <= 1'b0;
      receive_error_irq <= 1'b0;
      transfer_active_flag <= 1'b0;
      low_power_receive_state <= 1'b0;
      cpu_stopped <= 1'b0;
    end else if (clk_en) begin
      if (frm.done) begin
        serial_receive_data_reg <= frm.data;
      end
      full_q <= frm.done | (full_q & ~data_read);
      parity_error_flag <= (err_take & frm.parity_err) |
                           (parity_error_flag & ~clear_errors);
      framing_error_flag <= (err_take & frm.framing_err) |
                            (framing_error_flag & ~clear_errors);
      overrun_error_flag <= (err_take & overrun) |
                            (overrun_error_flag & ~clear_errors);
      // Error mode selects where an error is reported.
      receive_error_irq <= err_take & error_irq_output_control;
      receive_complete_irq <= good_done &
                              ~(err_take & error_irq_output_control);
      transfer_active_flag <= frm.busy;
      low_power_receive_state <= (pwr_q == PWR_LOW_POWER_RECEIVE_STATE);
      cpu_stopped <= ~in_run;
    end
  end
endmodule : low_power_receive_state_uart_rx

/* File: tb/low_power_receive_state_uart_rx_assertions.sv */
// Checker watching the ports of the low_power_receive_state receive path.
`timescale 1ns/10ps
module low_power_receive_state_uart_rx_assertions (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic serial_receive_pin,
  input wire logic hs_onchip_osc_clock,
  input wire logic low_power_receive_state_wake_enable,
  input wire logic low_power_receive_state_error_suppress,
  input wire logic parity_error_flag,
  input wire logic framing_error_flag,
  input wire logic overrun_error_flag,
  input wire logic receive_complete_irq,
  input wire logic receive_error_irq,
  input wire logic transfer_active_flag,
  input wire logic low_power_receive_state
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Low_power_receive_state needs a low line, permission and the on-chip clock two edges back.
  a_low_power_receive_state_entry_ok: assert property (
    $rose(low_power_receive_state) |->
    $past(low_power_receive_state_wake_enable && hs_onchip_osc_clock && !serial_receive_pin, 2))
    else $error("low_power_receive_state entered without cause");
  // Flags and the error pulse follow the suppress level seen at the edge that set them.
  a_suppress_flags: assert property (
    $past(low_power_receive_state_error_suppress) |->
    !$rose(parity_error_flag | framing_error_flag | overrun_error_flag))
    else $error("error flag set while suppressed");
  a_suppress_irq: assert property ($past(low_power_receive_state_error_suppress) |-> !receive_error_irq)
    else $error("error irq while suppressed");
  a_done_pulse: assert property (receive_complete_irq |=> !receive_complete_irq)
    else $error("complete irq longer than one cycle");
  a_err_pulse: assert property (receive_error_irq |=> !receive_error_irq)
    else $error("error irq longer than one cycle");
  a_wake_on_rx: assert property (
    receive_complete_irq && low_power_receive_state |-> ##[1:3] !low_power_receive_state)
    else $error("no wake after low_power_receive_state frame");
  a_glitch_no_rx: assert property (
    $fell(serial_receive_pin) ##1 serial_receive_pin[*8] |-> !transfer_active_flag)
    else $error("transfer kept after short pulse");
  // Main scenarios seen.
  cover property ($rose(low_power_receive_state));
  cover property (receive_complete_irq && low_power_receive_state);
  cover property (receive_error_irq);
endmodule : low_power_receive_state_uart_rx_assertions
bind low_power_receive_state_uart_rx low_power_receive_state_uart_rx_assertions u_chk (.*);

/* File: tb/serial_tx_model.sv */
// Model of the far-side serial transmitter.
`timescale 1ns/10ps
module serial_tx_model #(
  parameter int BIT_CLKS = 8
) (
  input wire logic ref_clk,
  output logic line
);
  // The line idles high outside frames.
  initial line = 1'b1;
  // Sends start, data LSB first, optional even parity and one stop bit.
  task automatic send(input logic [7:0] d, input logic pen, input logic bad);
    logic [10:0] b;
    b = {1'b1, pen ? (^d ^ bad) : 1'b1, d, 1'b0};
    for (int i = 0; i < (pen ? 11 : 10); i++) begin
      line = b[i];
      repeat (BIT_CLKS) @(negedge ref_clk);
    end
  endtask : send
  // Drops the line for one cycle only.
  task automatic glitch;
    line = 1'b0;
    @(negedge ref_clk);
    line = 1'b1;
    repeat (16) @(negedge ref_clk);
  endtask : glitch
endmodule : serial_tx_model

/* File: tb/low_power_receive_state_uart_rx_tb_top.sv */
// Self-checking testbench of the low_power_receive_state receive path.
`timescale 1ns/10ps
module low_power_receive_state_uart_rx_tb_top;
  import low_power_receive_state_rx_pkg::*;
  logic ref_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, parity_odd = 1'b0;
  logic serial_receive_pin, stop_req, cpu_wake, hs_onchip_osc_clock, low_power_receive_state_wake_enable;
  logic low_power_receive_state_error_suppress, error_irq_output_control, parity_en, data_read, clear_errors;
  logic [DATA_W-1:0] serial_receive_data_reg;
  logic parity_error_flag, framing_error_flag, overrun_error_flag, receive_complete_irq;
  logic receive_error_irq, transfer_active_flag, low_power_receive_state, cpu_stopped;
  logic [DATA_W-1:0] q[$];
  logic [31:0] seed = 32'h72144018;
  int errors = 0, check_count = 0, n_err = 0;
  logic ign = 1'b0;
  initial begin
    {stop_req, cpu_wake, low_power_receive_state_wake_enable, low_power_receive_state_error_suppress} = '0;
    {error_irq_output_control, parity_en, data_read, clear_errors} = '0;
    hs_onchip_osc_clock = 1'b1;
  end
  always #12.5 ref_clk = ~ref_clk;
  low_power_receive_state_uart_rx #(.BIT_DIV(16'h0007)) u_dut (.*);
  serial_tx_model #(.BIT_CLKS(8)) u_tx (.ref_clk(ref_clk), .line(serial_receive_pin));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
    @(negedge ref_clk);
  endtask : pulse
  // Sends a random byte; the note says whether a completion must follow.
  task automatic frame(input logic want);
    seed = lfsr(seed);
    if (want) q.push_back(seed[7:0]);
    u_tx.send(seed[7:0], 1'b0, 1'b0);
    repeat (6) @(negedge ref_clk);
    chk("pending frames", 8'h00, 8'(q.size()));
    pulse(data_read);
  endtask : frame
  // Takes the oldest note off the queue at each completion.
  always @(posedge ref_clk) begin
    if (receive_complete_irq === 1'b1 && q.size() > 0) chk("rx data", q.pop_front(),
      serial_receive_data_reg);
    else if (receive_complete_irq === 1'b1 && !ign) chk("spurious irq", 8'h00, 8'h01);
    if (receive_error_irq === 1'b1) n_err++;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    complete_run();
  end
  initial begin
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    chk("reset data", DATA_RESET, serial_receive_data_reg);
    chk("reset outputs", 8'h00, {parity_error_flag, framing_error_flag, overrun_error_flag,
      receive_complete_irq, receive_error_irq, transfer_active_flag, low_power_receive_state,
      cpu_stopped});
    frame(1'b1);
    $display("test run receive ended");
    // Stop without permission, then stop on a foreign clock.
    for (int i = 0; i < 2; i++) begin
      low_power_receive_state_wake_enable = i[0];
      hs_onchip_osc_clock = ~i[0];
      pulse(stop_req);
      frame(1'b0);
      chk("no low_power_receive_state", 8'h00, {7'h00, low_power_receive_state});
      pulse(cpu_wake);
    end
    hs_onchip_osc_clock = 1'b1;
    pulse(stop_req);
    frame(1'b1);
    chk("cpu awake", 8'h00, {7'h00, cpu_stopped});
    pulse(stop_req);
    u_tx.glitch();
    chk("low_power_receive_state kept", 8'h01, {7'h00, low_power_receive_state});
    pulse(cpu_wake);
    $display("test low_power_receive_state ended");
    {parity_en, low_power_receive_state_error_suppress, error_irq_output_control, ign} = 4'hF;
    low_power_receive_state_wake_enable = 1'b0;
    pulse(clear_errors);
    pulse(data_read);
    low_power_receive_state_wake_enable = 1'b1;
    for (int i = 0; i < 2; i++) begin
      if (i == 0) pulse(stop_req);
      u_tx.send(8'hA5, 1'b1, 1'b1);
      repeat (6) @(negedge ref_clk);
      chk("error flags", {5'h00, i[0], 2'b00}, {5'h00, parity_error_flag, framing_error_flag,
        overrun_error_flag});
      chk("error irqs", {7'h00, i[0]}, 8'(n_err));
      pulse(cpu_wake);
      pulse(data_read);
      low_power_receive_state_error_suppress = 1'b0;
    end
    $display("test error suppress ended");
    // Odd parity is accepted, then a bad parity only sets its flag with no error pulse.
    {parity_odd, error_irq_output_control, ign} = 3'b100;
    pulse(clear_errors);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      q.push_back(seed[7:0]);
      u_tx.send(seed[7:0], 1'b1, ~i[0]);
      repeat (6) @(negedge ref_clk);
      chk("pending frames", 8'h00, 8'(q.size()));
      chk("odd parity flag", {7'h00, i[0]}, {7'h00, parity_error_flag});
      chk("error irqs", 8'h01, 8'(n_err));
      pulse(data_read);
    end
    $display("test odd parity ended");
    complete_run();
  end
endmodule : low_power_receive_state_uart_rx_tb_top
